// *** hdl/pud_device.sv ***
// Profile select, buffered update, automatic update and power-down logic
// of the synthesizer. Assumes ref_clk is the system clock and that the
// serial-port writes arrive already decoded on the link write port.
//
// Behaviour
// - Profile pins select profile 0 to 7.
// - RAM enable picks tone or RAM format.
// - Profile pins sampled at sync clock rise.
// - Written data stays buffered until update.
// - Sync clock is system clock over four.
// - Update pin input, rising edge transfers.
// - Profile pin change also transfers buffer.
// - Asynchronous strobe adds one-period jitter.
// - Internal update mode drives update pin out.
// - Output pulse width 12, 24, 48, 96.
// - Quarter-rate clock prescaled, then 32-bit count.
// - Update rate is system over 2^(A+2)*B.
// - Reset rate select zero, rate 0xFFFF.
// - Rate at most three holds pin high.
// - Four software power-down bits, pin low.
// - Core down blocks writes except clearing.
// - Sleep pin high powers down all four.
// - Control bit picks full or fast recovery.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "pud_regs.svh"
module pud_device (
  input wire logic ref_clk,
  input wire logic rst,
  pud_link_if.device link,
  output pud_pkg::word_t activeProfileWord,
  output logic ramFormat,
  output pud_pkg::pd_t powerDown,
  output logic fastRecovery,
  output logic transferPulse
);
  pud_pkg::word_t bufferRegs [16];
  pud_pkg::word_t activeRegs [16];
  logic [1:0] divCount;
  logic syncTick;
  pud_pkg::profile_t profMeta;
  pud_pkg::profile_t profSync;
  pud_pkg::profile_t profSampled;
  logic updMeta;
  logic updSync;
  logic updPrev;
  logic updSeen;
  logic sleepMeta;
  logic sleepSync;
  logic profChange;
  logic extRise;
  logic doTransfer;
  logic wrAccept;
  logic autoOn;
  logic staticHigh;
  logic preTick;
  logic autoFire;
  logic [1:0] rateSel;
  logic [2:0] preMask;
  logic [2:0] preCount;
  pud_pkg::word_t rateCount;
  pud_pkg::word_t rateLimit;
  logic [6:0] widthLeft;
  logic [6:0] widthLoad;
  pud_pkg::word_t funcOne;
  pud_pkg::word_t funcTwo;

  assign funcOne = activeRegs[`PUD_FUNC_ONE_IDX];
  assign funcTwo = activeRegs[`PUD_FUNC_TWO_IDX];

  // The sync clock rises at the edge where divCount leaves 1, so every
  // sync-domain action below is an enable on that same edge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divCount <= 2'h0;
      link.syncClk <= 1'b0;
    end else begin
      divCount <= divCount + 2'h1;
      link.syncClk <= (divCount == 2'h1) || (divCount == 2'h2);
    end
  end
  assign syncTick = (divCount == `PUD_SYNC_RISE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      profMeta <= 3'h0;
      profSync <= 3'h0;
      updMeta <= 1'b0;
      updSync <= 1'b0;
      updPrev <= 1'b0;
      sleepMeta <= 1'b0;
      sleepSync <= 1'b0;
    end else begin
      profMeta <= link.profileSel;
      profSync <= profMeta;
      updMeta <= link.updatePin;
      updSync <= updMeta;
      updPrev <= updSync;
      sleepMeta <= link.sleepPin;
      sleepSync <= sleepMeta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      profSampled <= 3'h0;
    end else if (syncTick) begin
      profSampled <= profSync;
    end
  end
  assign profChange = syncTick && (profSync != profSampled);

  // A strobe edge is held until the next sync rise; an edge that misses
  // it waits one more sync period, which is the latency jitter.
  assign extRise = updSync && !updPrev && !autoOn;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      updSeen <= 1'b0;
    end else if (extRise) begin
      updSeen <= 1'b1;
    end else if (syncTick) begin
      updSeen <= 1'b0;
    end
  end

  assign doTransfer = (syncTick && (updSeen || profChange)) || autoFire;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transferPulse <= 1'b0;
    end else begin
      transferPulse <= doTransfer;
    end
  end

  // A core that is powered down still takes a write clearing its own
  // power-down bit, otherwise the part could never be woken again.
  assign wrAccept = link.wrValid && (!powerDown.digital ||
    ((link.wrAddr == `PUD_FUNC_ONE_IDX) &&
     !link.wrData[`PUD_PD_DIGITAL_BIT]));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        bufferRegs[i] <= 32'h00000000;
      end
      bufferRegs[`PUD_FUNC_ONE_IDX] <= `PUD_FUNC_ONE_RESET;
      bufferRegs[`PUD_FUNC_TWO_IDX] <= `PUD_FUNC_TWO_RESET;
      bufferRegs[`PUD_RATE_IDX] <= `PUD_RATE_RESET;
    end else if (wrAccept) begin
      bufferRegs[link.wrAddr] <= link.wrData;
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_active
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        if (g == `PUD_RATE_IDX) begin
          activeRegs[g] <= `PUD_RATE_RESET;
        end else begin
          activeRegs[g] <= 32'h00000000;
        end
      end else if (doTransfer) begin
        activeRegs[g] <= bufferRegs[g];
      end
    end
  end

  assign autoOn = funcTwo[`PUD_AUTO_UPD_BIT];
  assign rateSel = funcTwo[`PUD_RATE_SEL_MSB:`PUD_RATE_SEL_LSB];
  assign rateLimit = activeRegs[`PUD_RATE_IDX];
  assign staticHigh = (rateLimit <= `PUD_STATIC_LIMIT);

  always_comb begin
    case (rateSel)
      2'h0: preMask = 3'h0;
      2'h1: preMask = 3'h1;
      2'h2: preMask = 3'h3;
      default: preMask = 3'h7;
    endcase
  end

  // The prescaler divides the quarter-rate tick by 1, 2, 4 or 8.
  assign preTick = syncTick && autoOn &&
    ((preCount & preMask) == preMask);
  assign autoFire = preTick &&
    ((rateCount + 32'h00000001) >= rateLimit);
  always_ff @(posedge ref_clk) begin
    if (rst || !autoOn) begin
      preCount <= 3'h0;
    end else if (syncTick) begin
      preCount <= preCount + 3'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !autoOn) begin
      rateCount <= 32'h00000000;
    end else if (autoFire) begin
      rateCount <= 32'h00000000;
    end else if (preTick) begin
      rateCount <= rateCount + 32'h00000001;
    end
  end

  assign widthLoad = 7'(`PUD_WIDTH_BASE << rateSel);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.devUpdOut <= 1'b0;
      link.devUpdOe <= 1'b0;
      widthLeft <= 7'h00;
    end else begin
      link.devUpdOe <= autoOn;
      if (!autoOn) begin
        link.devUpdOut <= 1'b0;
        widthLeft <= 7'h00;
      end else if (staticHigh) begin
        link.devUpdOut <= 1'b1;
        widthLeft <= 7'h00;
      end else if (autoFire) begin
        link.devUpdOut <= 1'b1;
        widthLeft <= widthLoad - 7'h01;
      end else if (widthLeft != 7'h00) begin
        widthLeft <= widthLeft - 7'h01;
      end else begin
        link.devUpdOut <= 1'b0;
      end
    end
  end

  // All four sections go down on the pin; the control bit only tells the
  // analog side whether to keep bias and clocking alive.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      powerDown <= 4'h0;
      fastRecovery <= 1'b0;
    end else if (sleepSync) begin
      powerDown <= 4'hF;
      fastRecovery <= funcOne[`PUD_EXT_CTL_BIT];
    end else begin
      powerDown <= funcOne[`PUD_PD_MSB:`PUD_PD_LSB];
      fastRecovery <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      activeProfileWord <= 32'h00000000;
      ramFormat <= 1'b0;
    end else begin
      activeProfileWord <=
        activeRegs[{`PUD_PROF_BASE, profSampled}];
      ramFormat <= funcOne[`PUD_RAM_EN_BIT];
    end
  end
endmodule : pud_device

// *** hdl/pud_regs.svh ***
// Register indices, field positions, reset values and counts of the
// profile, update and power-down logic and of its controller.
// Assumes a 200 MHz system clock that also serves as ref_clk.
`ifndef PUD_REGS_SVH
`define PUD_REGS_SVH
`define PUD_FUNC_ONE_IDX 4'h0
`define PUD_FUNC_TWO_IDX 4'h1
`define PUD_RATE_IDX 4'h4
`define PUD_PROF_BASE 1'b1
`define PUD_RAM_EN_BIT 31
`define PUD_PD_DIGITAL_BIT 7
`define PUD_PD_MSB 7
`define PUD_PD_LSB 4
`define PUD_EXT_CTL_BIT 3
`define PUD_AUTO_UPD_BIT 23
`define PUD_RATE_SEL_MSB 15
`define PUD_RATE_SEL_LSB 14
`define PUD_FUNC_ONE_RESET 32'h00000000
`define PUD_FUNC_TWO_RESET 32'h00000000
`define PUD_RATE_RESET 32'h0000FFFF
`define PUD_STATIC_LIMIT 32'h00000003
`define PUD_SYNC_RISE 2'h1
`define PUD_WIDTH_BASE 7'h0C
`define PUD_STROBE_CYCLES 4'h8
`define CTL_CTRL_OFS 5'h00
`define CTL_WADDR_OFS 5'h04
`define CTL_WDATA_OFS 5'h08
`define CTL_UPDATE_OFS 5'h0C
`define CTL_STATUS_OFS 5'h10
`define CTL_PROF_MSB 2
`define CTL_SLEEP_BIT 3
`define CTL_DRIVE_BIT 4
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// *** hdl/pud_pkg.sv ***
// Types shared by both ends of the profile and update link.
// Assumes the constants of pud_regs.svh for all figures.
package pud_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] reg_idx_t;
  typedef logic [2:0] profile_t;
  typedef struct packed {
    logic digital;
    logic dac;
    logic aux;
    logic refclk;
  } pd_t;
endpackage : pud_pkg

// *** hdl/pud_link_if.sv ***
// Pins between the synthesizer control logic and its external controller.
// Assumes both ends run on the same ref_clk; the shared update pin is
// resolved here from the two drivers and their enables.
`timescale 1ns/1ps
interface pud_link_if;
  logic syncClk;
  pud_pkg::profile_t profileSel;
  logic devUpdOut;
  logic devUpdOe;
  logic ctrlUpdOut;
  logic ctrlUpdOe;
  logic updatePin;
  logic sleepPin;
  logic wrValid;
  pud_pkg::reg_idx_t wrAddr;
  pud_pkg::word_t wrData;

  // An undriven pin reads low, as with a pull-down.
  assign updatePin = devUpdOe ? devUpdOut : (ctrlUpdOe & ctrlUpdOut);

  modport device (
    output syncClk,
    output devUpdOut,
    output devUpdOe,
    input profileSel,
    input updatePin,
    input sleepPin,
    input wrValid,
    input wrAddr,
    input wrData
  );
  modport controller (
    input syncClk,
    input updatePin,
    output profileSel,
    output ctrlUpdOut,
    output ctrlUpdOe,
    output sleepPin,
    output wrValid,
    output wrAddr,
    output wrData
  );
endinterface : pud_link_if

// *** hdl/pud_controller.sv ***
// External controller that drives the profile, update and sleep pins and
// the register write port, ordered by software over AXI4-Lite.
// Assumes the same ref_clk as the device; pins from it are synchronised.
`timescale 1ns/1ps
`include "pud_regs.svh"
module pud_controller (
  input wire logic ref_clk,
  input wire logic rst,
  pud_link_if.controller link,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [4:0] awAddrQ;
  pud_pkg::word_t wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  pud_pkg::word_t merged;
  logic [4:0] ctrlReg;
  pud_pkg::reg_idx_t wrAddrReg;
  logic [3:0] pulseLeft;
  logic syncMeta;
  logic syncSync;
  logic syncPrev;
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic [15:0] riseCount;
  logic pending;

  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_comb begin
    merged = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = wStrbQ[b] ? wDataQ[8*b +: 8] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      awAddrQ <= 5'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddrQ < `CTL_STATUS_OFS && awAddrQ[1:0] == 2'h0)
          ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrlReg <= 5'h00;
      wrAddrReg <= 4'h0;
      link.wrValid <= 1'b0;
      link.wrAddr <= 4'h0;
      link.wrData <= 32'h00000000;
    end else begin
      link.wrValid <= 1'b0;
      if (doWrite && awAddrQ == `CTL_CTRL_OFS && wStrbQ[0]) begin
        ctrlReg <= merged[4:0];
      end
      if (doWrite && awAddrQ == `CTL_WADDR_OFS && wStrbQ[0]) begin
        wrAddrReg <= merged[3:0];
      end
      if (doWrite && awAddrQ == `CTL_WDATA_OFS) begin
        link.wrValid <= 1'b1;
        link.wrAddr <= wrAddrReg;
        link.wrData <= merged;
      end
    end
  end

  // An update strobe is a fixed pulse that outlasts one sync period, so
  // the device always sees a clean edge whatever the phase.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.ctrlUpdOut <= 1'b0;
      pulseLeft <= 4'h0;
    end else if (doWrite && awAddrQ == `CTL_UPDATE_OFS) begin
      link.ctrlUpdOut <= 1'b1;
      pulseLeft <= `PUD_STROBE_CYCLES - 4'h1;
    end else if (pulseLeft != 4'h0) begin
      pulseLeft <= pulseLeft - 4'h1;
    end else begin
      link.ctrlUpdOut <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncMeta <= 1'b0;
      syncSync <= 1'b0;
      syncPrev <= 1'b0;
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      syncMeta <= link.syncClk;
      syncSync <= syncMeta;
      syncPrev <= syncSync;
      pinMeta <= link.updatePin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.profileSel <= 3'h0;
      link.sleepPin <= 1'b0;
      link.ctrlUpdOe <= 1'b0;
      riseCount <= 16'h0000;
    end else begin
      if (syncSync && !syncPrev) begin
        link.profileSel <= ctrlReg[`CTL_PROF_MSB:0];
      end
      link.sleepPin <= ctrlReg[`CTL_SLEEP_BIT];
      link.ctrlUpdOe <= ctrlReg[`CTL_DRIVE_BIT];
      if (pinSync && !pinPrev) begin
        riseCount <= riseCount + 16'h0001;
      end
    end
  end
  assign pending = (link.profileSel != ctrlReg[`CTL_PROF_MSB:0]);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      case (s_axi_araddr)
        `CTL_CTRL_OFS: s_axi_rdata <= {27'h0000000, ctrlReg};
        `CTL_WADDR_OFS: s_axi_rdata <= {28'h0000000, wrAddrReg};
        `CTL_WDATA_OFS: s_axi_rdata <= link.wrData;
        `CTL_UPDATE_OFS: s_axi_rdata <= 32'h00000000;
        `CTL_STATUS_OFS: s_axi_rdata <= {riseCount, 12'h000, pending,
          syncSync, link.ctrlUpdOut, pinSync};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pud_controller

// *** tb/pud_checker.sv ***
// Assertions on the link pins between the synthesizer logic and controller.
// Assumes one ref_clk domain with a synchronous, active-high rst.
`timescale 1ns/1ps
module pud_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic syncClk,
  input wire pud_pkg::profile_t profileSel,
  input wire logic devUpdOut,
  input wire logic devUpdOe,
  input wire logic ctrlUpdOut,
  input wire logic ctrlUpdOe,
  input wire logic wrValid
);
  logic [15:0] hiCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Saturates so that a long static level never wraps into a legal width.
  always_ff @(posedge ref_clk) begin
    if (rst || !(devUpdOe && devUpdOut)) begin
      hiCnt <= 16'h0000;
    end else if (hiCnt != 16'hFFFF) begin
      hiCnt <= hiCnt + 16'h0001;
    end
  end
  sequence syncPeriod;
    syncClk ##1 !syncClk ##1 !syncClk ##1 syncClk;
  endsequence
  sequence ctrlStrobe;
    ctrlUpdOut [*8] ##1 !ctrlUpdOut;
  endsequence
  a_sync_divide: assert property ($rose(syncClk) |=> syncPeriod)
    else $error("sync clock is not system clock over four");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !syncClk && !devUpdOe && !ctrlUpdOe)
    else $error("link outputs active after reset");
  a_pulse_width: assert property (
    devUpdOe && $fell(devUpdOut) |->
      hiCnt inside {16'h000C, 16'h0018, 16'h0030, 16'h0060})
    else $error("update pulse width is not a legal setting");
  a_static_high: assert property (
    devUpdOe && hiCnt > 16'h0060 |-> devUpdOut)
    else $error("static update level dropped");
  a_manual_low: assert property (!devUpdOe |-> !devUpdOut)
    else $error("update pin driven high outside auto mode");
  a_ctrl_strobe: assert property ($rose(ctrlUpdOut) |-> ctrlStrobe)
    else $error("controller strobe is not eight cycles");
  a_write_pulse: assert property (wrValid |=> !wrValid)
    else $error("write valid longer than one cycle");
  a_profile_setup: assert property (
    $changed(profileSel) |-> !syncClk)
    else $error("profile changed near sync clock rise");
endmodule : pud_checker

// *** tb/profile_update_powerdown_ctrl_tb.sv ***
// Bench joining the synthesizer logic to its controller over the link.
// Assumes the controller map of the register header; a model here
// predicts each transfer made outside automatic mode and the automatic update period.
`timescale 1ns/1ps
`include "pud_regs.svh"
module profile_update_powerdown_ctrl_tb;
  typedef struct packed {
    pud_pkg::word_t word;
    logic ram;
    pud_pkg::pd_t pd;
  } xfer_t;
  logic ref_clk = 1'b0, rst = 1'b1, autoOn = 1'b0, prevOut = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ramFormat;
  logic fastRecovery, transferPulse, xferLate = 1'b0;
  logic [1:0] bresp, rresp;
  pud_pkg::word_t wdata = 32'h00000000, funcOne = 32'h00000000;
  pud_pkg::word_t rdata, activeProfileWord;
  pud_pkg::word_t pw [8];
  pud_pkg::pd_t powerDown;
  pud_pkg::profile_t prof = 3'h0;
  xfer_t seenXfer;
  xfer_t expQ[$];
  int perQ[$];
  int mismatches = 0, n_compared = 0, cyc = 0, riseN = 0, lastRise = 0;
  assign seenXfer = {activeProfileWord, ramFormat, powerDown};
  pud_link_if link ();
  pud_device pud_device_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .activeProfileWord(activeProfileWord), .ramFormat(ramFormat),
    .powerDown(powerDown), .fastRecovery(fastRecovery),
    .transferPulse(transferPulse));
  pud_controller pud_controller_i (.ref_clk(ref_clk), .rst(rst),
    .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  pud_checker pud_checker_i (.ref_clk(ref_clk), .rst(rst),
    .syncClk(link.syncClk), .profileSel(link.profileSel),
    .devUpdOut(link.devUpdOut), .devUpdOe(link.devUpdOe),
    .ctrlUpdOut(link.ctrlUpdOut), .ctrlUpdOe(link.ctrlUpdOe),
    .wrValid(link.wrValid));
  always #2.5 ref_clk = ~ref_clk;
  task automatic chkVal(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chkVal
  task automatic chkXfer(input xfer_t e, input xfer_t g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED transfer expected %h seen %h", e, g);
    end
  endtask : chkXfer
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Each bus task ends one edge after lowering ready, so back-to-back
  // calls never assign the same signal twice in one time step.
  task automatic axiWr(input logic [4:0] a, input pud_pkg::word_t d,
      input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chkVal("bvalid", 32'h1, {31'h0, bvalid});
    chkVal("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge ref_clk);
  endtask : axiWr
  task automatic axiRd(input logic [4:0] a, input pud_pkg::word_t ed,
      input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chkVal("rvalid", 32'h1, {31'h0, rvalid});
    chkVal("rdata", ed, rdata);
    chkVal("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge ref_clk);
  endtask : axiRd
  task automatic devWr(input logic [3:0] i, input pud_pkg::word_t d);
    axiWr(`CTL_WADDR_OFS, {28'h0, i}, `AXI_OKAY);
    axiWr(`CTL_WDATA_OFS, d, `AXI_OKAY);
  endtask : devWr
  task automatic setCtrl();
    axiWr(`CTL_CTRL_OFS, {27'h0, 1'b1, sleep, prof}, `AXI_OKAY);
  endtask : setCtrl
  task automatic update();
    axiWr(`CTL_UPDATE_OFS, 32'h0, `AXI_OKAY);
  endtask : update
  task automatic pushExp();
    expQ.push_back({pw[prof], funcOne[31], sleep ? 4'hF : funcOne[7:4]});
  endtask : pushExp
  task automatic waitQ();
    int n;
    n = 0;
    while ((expQ.size() != 0 || perQ.size() != 0) && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    chkVal("pending", 32'h0, 32'(expQ.size() + perQ.size()));
  endtask : waitQ
  task automatic waitPd(input pud_pkg::pd_t e, input logic ef);
    int n;
    n = 0;
    while ((powerDown !== e || fastRecovery !== ef) && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    chkVal("power down", {28'h0, e}, {28'h0, powerDown});
    chkVal("fast recovery", {31'h0, ef}, {31'h0, fastRecovery});
  endtask : waitPd
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prevOut <= link.devUpdOut;
    // The pulse rises with the copy; the outputs follow one cycle later.
    xferLate <= !rst && !autoOn && transferPulse === 1'b1;
    if (xferLate) begin
      if (expQ.size() == 0) begin
        chkVal("unexpected transfer", 32'h0, 32'h1);
      end else begin
        chkXfer(expQ.pop_front(), seenXfer);
      end
    end
    if (perQ.size() == 0) begin
      riseN <= 0;
    end else if (link.devUpdOe === 1'b1 && link.devUpdOut === 1'b1
        && prevOut === 1'b0) begin
      riseN <= riseN + 1;
      lastRise <= cyc;
      if (riseN == 3) chkVal("period", perQ.pop_front(), cyc - lastRise);
    end
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    int n, hi;
    void'($urandom(32'h85C3));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    axiRd(`CTL_CTRL_OFS, 32'h0, `AXI_OKAY);
    axiRd(5'h14, 32'h0, `AXI_SLVERR);
    axiWr(`CTL_STATUS_OFS, 32'h1, `AXI_SLVERR);
    axiWr(5'h02, 32'h1, `AXI_SLVERR);
    setCtrl();
    for (int p = 0; p < 8; p++) begin
      pw[p] = $urandom();
      devWr(4'(8 + p), pw[p]);
    end
    pushExp();
    update();
    waitQ();
    for (int p = 1; p <= 8; p++) begin
      prof = 3'(p);
      // Profile 5 is rewritten first: only the change may copy it.
      if (p == 5) begin
        pw[5] = $urandom();
        devWr(4'hD, pw[5]);
      end
      pushExp();
      setCtrl();
      waitQ();
    end
    for (int k = 0; k < 4; k++) begin
      funcOne = (32'h10 << k) | (k[0] ? 32'h80000000 : 32'h0);
      devWr(`PUD_FUNC_ONE_IDX, funcOne);
      pushExp();
      update();
      waitQ();
    end
    devWr(4'h9, ~pw[1]);
    funcOne = 32'h0;
    devWr(`PUD_FUNC_ONE_IDX, funcOne);
    pushExp();
    update();
    waitQ();
    prof = 3'h1;
    pushExp();
    setCtrl();
    waitQ();
    for (int f = 0; f < 2; f++) begin
      funcOne = f ? 32'h48 : 32'h50;
      devWr(`PUD_FUNC_ONE_IDX, funcOne);
      pushExp();
      update();
      waitQ();
      sleep = 1'b1;
      setCtrl();
      waitPd(4'hF, f[0]);
      pushExp();
      update();
      waitQ();
      sleep = 1'b0;
      setCtrl();
      waitPd(funcOne[7:4], 1'b0);
    end
    autoOn <= 1'b1;
    devWr(`PUD_RATE_IDX, 32'h4);
    for (int a = 0; a < 4; a++) begin
      devWr(`PUD_FUNC_TWO_IDX, 32'h00800000 | (a << 14));
      if (a == 0) update();
      perQ.push_back(16 << a);
      waitQ();
    end
    devWr(`PUD_RATE_IDX, 32'h3);
    n = 0;
    hi = 0;
    while (hi < 200 && n < 3000) begin
      @(posedge ref_clk);
      n++;
      hi = (link.updatePin === 1'b1) ? hi + 1 : 0;
    end
    chkVal("static pin", 32'hC8, hi);
    devWr(`PUD_FUNC_TWO_IDX, 32'h0);
    n = 0;
    while (link.devUpdOe !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chkVal("pin output", 32'h0, {31'h0, link.devUpdOe});
    autoOn <= 1'b0;
    @(posedge ref_clk);
    pushExp();
    update();
    waitQ();
    end_sim();
  end
endmodule : profile_update_powerdown_ctrl_tb
